// *** asmd_top.sv ***
`timescale 1ns/1ps
`include "asmd_defines.svh"

module asmd_top
    import asmd_pkg::*;
(
    // system clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    // convert-start pin
    input wire logic cnvst_n,
    // configuration
    input wire logic [1:0] repeat_count_sel,
    input wire logic avg_request,
    // converter core
    output logic conv_start_reg,
    output logic [3:0] conv_channel_reg,
    input wire logic conv_done,
    input wire logic [11:0] conv_result,
    // mode status
    output logic [3:0] scan_mode_reg,
    output logic [3:0] channel_number_field_reg,
    output logic [3:0] ctrl_bits_reg,
    output logic software_convert_bit_reg,
    output logic ext_clock_mode_reg,
    output logic avg_active_reg,
    output logic busy_reg,
    // manual result
    output logic [15:0] manual_result_reg,
    output logic manual_valid_reg,
    // fifo drain
    output logic fifo_valid,
    input wire logic fifo_ready,
    output logic [15:0] fifo_data
);
    // link domain
    logic [3:0] bit_cnt_reg;
    logic [14:0] shift_reg;
    logic [15:0] word_hold_reg;
    logic word_tog_reg;
    logic frame_clr;

    // crossings
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic cnv_s1_reg;
    logic cnv_s2_reg;
    logic cnv_s3_reg;
    logic word_evt;
    logic cs_rise;
    logic cnvst_fall;

    // decode
    asmd_mode_t word_dec;
    logic mode_write;
    logic manual_pending_reg;

    // sequencer
    asmd_seq_t seq_reg;
    asmd_seq_t seq_next;
    logic [3:0] count_reg;
    logic [3:0] limit_reg;
    logic run_manual_reg;
    logic run_repeat_reg;
    logic internal_mode;
    logic int_trigger;
    logic man_trigger;
    asmd_entry_t entry_reg;
    logic push_ready;
    logic push_done;
    logic run_last;

    function automatic asmd_mode_t decode_word(input logic [15:0] w);
        asmd_mode_t m;
        m.scan = w[`ASMD_SCAN_HI:`ASMD_SCAN_LO];
        m.channel = w[`ASMD_CHAN_HI:`ASMD_CHAN_LO];
        m.ctrl = w[`ASMD_CTRL_HI:`ASMD_CTRL_LO];
        m.swconv = w[`ASMD_SOFTWARE_CONVERT_BIT_POS];
        return m;
    endfunction

    function automatic logic is_internal(input logic [3:0] s);
        return (s == ASMD_SCAN_REPEAT) || (s == ASMD_SCAN_STD_INT);
    endfunction

    // frame shifter on the link clock; frame end clears the bit count
    assign frame_clr = cs_n || !rst_n;

    always_ff @(posedge sclk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            bit_cnt_reg <= 4'h0;
        end
        else
        begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg <= 15'h0000;
        end
        else if (!cs_n)
        begin
            shift_reg <= {shift_reg[13:0], din};
        end
    end

    // whole word held stable, announced by a toggle
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_hold_reg <= 16'h0000;
            word_tog_reg <= 1'b0;
        end
        else if (!cs_n && bit_cnt_reg == `ASMD_LAST_BIT)
        begin
            word_hold_reg <= {shift_reg, din};
            word_tog_reg <= !word_tog_reg;
        end
    end

    // two-stage synchronisers, third stage for edges
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            cnv_s1_reg <= 1'b1;
            cnv_s2_reg <= 1'b1;
            cnv_s3_reg <= 1'b1;
        end
        else
        begin
            tog_s1_reg <= word_tog_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            cnv_s1_reg <= cnvst_n;
            cnv_s2_reg <= cnv_s1_reg;
            cnv_s3_reg <= cnv_s2_reg;
        end
    end

    assign word_evt = tog_s2_reg ^ tog_s3_reg;
    assign cs_rise = cs_s2_reg && !cs_s3_reg;
    assign cnvst_fall = cnv_s3_reg && !cnv_s2_reg;

    assign word_dec = decode_word(word_hold_reg);
    assign mode_write = word_evt && !word_hold_reg[`ASMD_REG_SEL_POS];

    // mode control register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scan_mode_reg <= `ASMD_SCAN_RESET;
            channel_number_field_reg <= `ASMD_CHAN_RESET;
            ctrl_bits_reg <= `ASMD_CTRL_RESET;
        end
        else if (mode_write)
        begin
            ctrl_bits_reg <= word_dec.ctrl;
            if (word_dec.scan != ASMD_SCAN_HOLD)
            begin
                scan_mode_reg <= word_dec.scan;
                channel_number_field_reg <= word_dec.channel;
            end
        end
    end

    // software convert: a new write wins over its consumption
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            software_convert_bit_reg <= 1'b0;
        end
        else if (mode_write)
        begin
            software_convert_bit_reg <= word_dec.swconv;
        end
        else if (int_trigger && seq_reg == ASMD_SEQ_IDLE)
        begin
            software_convert_bit_reg <= 1'b0;
        end
    end

    // manual request per frame
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            manual_pending_reg <= 1'b0;
        end
        else if (mode_write && word_dec.scan == ASMD_SCAN_MANUAL)
        begin
            manual_pending_reg <= 1'b1;
        end
        else if (man_trigger)
        begin
            manual_pending_reg <= 1'b0;
        end
    end

    // clock mode and averaging reflect the scan mode
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_clock_mode_reg <= 1'b1;
            avg_active_reg <= 1'b0;
        end
        else
        begin
            ext_clock_mode_reg <= !is_internal(scan_mode_reg);
            avg_active_reg <= avg_request && is_internal(scan_mode_reg);
        end
    end

    assign internal_mode = is_internal(scan_mode_reg);
    assign int_trigger = internal_mode &&
        (cnvst_fall || (cs_rise && software_convert_bit_reg));
    assign man_trigger = seq_reg == ASMD_SEQ_IDLE &&
        scan_mode_reg == ASMD_SCAN_MANUAL && manual_pending_reg;
    assign push_done = seq_reg == ASMD_SEQ_PUSH && push_ready;
    assign run_last = (count_reg == limit_reg);

    // sequencer state
    always_comb
    begin
        seq_next = seq_reg;
        case (seq_reg)
            ASMD_SEQ_IDLE:
            begin
                if (man_trigger || int_trigger)
                begin
                    seq_next = ASMD_SEQ_START;
                end
            end
            ASMD_SEQ_START:
            begin
                seq_next = ASMD_SEQ_WAIT;
            end
            ASMD_SEQ_WAIT:
            begin
                if (conv_done)
                begin
                    seq_next = run_manual_reg ? ASMD_SEQ_IDLE :
                        ASMD_SEQ_PUSH;
                end
            end
            ASMD_SEQ_PUSH:
            begin
                if (push_ready)
                begin
                    seq_next = run_last ? ASMD_SEQ_IDLE : ASMD_SEQ_START;
                end
            end
            default:
            begin
                seq_next = ASMD_SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_reg <= ASMD_SEQ_IDLE;
        end
        else
        begin
            seq_reg <= seq_next;
        end
    end

    // run setup and stepping
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= 4'h0;
            limit_reg <= 4'h0;
            run_manual_reg <= 1'b0;
            run_repeat_reg <= 1'b0;
            conv_channel_reg <= 4'h0;
        end
        else if (man_trigger)
        begin
            run_manual_reg <= 1'b1;
            run_repeat_reg <= 1'b0;
            conv_channel_reg <= channel_number_field_reg;
        end
        else if (seq_reg == ASMD_SEQ_IDLE && int_trigger)
        begin
            run_manual_reg <= 1'b0;
            count_reg <= 4'h0;
            if (scan_mode_reg == ASMD_SCAN_REPEAT)
            begin
                run_repeat_reg <= 1'b1;
                limit_reg <= {repeat_count_sel, 2'b11};
                conv_channel_reg <= channel_number_field_reg;
            end
            else
            begin
                run_repeat_reg <= 1'b0;
                limit_reg <= channel_number_field_reg;
                conv_channel_reg <= 4'h0;
            end
        end
        else if (push_done && !run_last)
        begin
            count_reg <= count_reg + 4'h1;
            if (!run_repeat_reg)
            begin
                conv_channel_reg <= conv_channel_reg + 4'h1;
            end
        end
    end

    // start pulse and busy flag
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_start_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            conv_start_reg <= seq_next == ASMD_SEQ_START;
            busy_reg <= seq_next != ASMD_SEQ_IDLE;
        end
    end

    // result capture
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            entry_reg <= '0;
            manual_result_reg <= 16'h0000;
            manual_valid_reg <= 1'b0;
        end
        else if (seq_reg == ASMD_SEQ_WAIT && conv_done)
        begin
            entry_reg <= {conv_channel_reg, conv_result};
            if (run_manual_reg)
            begin
                manual_result_reg <= {conv_channel_reg, conv_result};
                manual_valid_reg <= 1'b1;
            end
        end
        else if (man_trigger)
        begin
            manual_valid_reg <= 1'b0;
        end
    end

    // results of internal runs queue here; a full fifo stalls the run
    asmd_fifo #(
        .WIDTH(`ASMD_FIFO_W),
        .DEPTH(`ASMD_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(seq_reg == ASMD_SEQ_PUSH),
        .in_ready(push_ready),
        .in_data(entry_reg),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data),
        .flush(1'b0)
    );
endmodule

// *** asmd_defines.svh ***
`ifndef ASMD_DEFINES_SVH
`define ASMD_DEFINES_SVH

// serial word layout
`define ASMD_WORD_W 16
`define ASMD_REG_SEL_POS 15
`define ASMD_SCAN_HI 14
`define ASMD_SCAN_LO 11
`define ASMD_CHAN_HI 10
`define ASMD_CHAN_LO 7
`define ASMD_CTRL_HI 6
`define ASMD_CTRL_LO 3
`define ASMD_SOFTWARE_CONVERT_BIT_POS 1
`define ASMD_LAST_BIT 4'hF

// reset values
`define ASMD_SCAN_RESET 4'h1
`define ASMD_CHAN_RESET 4'h0
`define ASMD_CTRL_RESET 4'h0

// data path
`define ASMD_RESULT_W 12
`define ASMD_FIFO_W 16
`define ASMD_FIFO_DEPTH 16

`endif

// *** asmd_pkg.sv ***
package asmd_pkg;

    typedef enum logic [3:0]
    {
        ASMD_SCAN_HOLD = 4'b0000,
        ASMD_SCAN_MANUAL = 4'b0001,
        ASMD_SCAN_REPEAT = 4'b0010,
        ASMD_SCAN_STD_INT = 4'b0011
    } asmd_scan_t;

    typedef enum logic [1:0]
    {
        ASMD_SEQ_IDLE = 2'b00,
        ASMD_SEQ_START = 2'b01,
        ASMD_SEQ_WAIT = 2'b10,
        ASMD_SEQ_PUSH = 2'b11
    } asmd_seq_t;

    // mode control word as decoded
    typedef struct packed
    {
        logic [3:0] scan;
        logic [3:0] channel;
        logic [3:0] ctrl;
        logic swconv;
    } asmd_mode_t;

    // one fifo entry: channel tag then result
    typedef struct packed
    {
        logic [3:0] channel;
        logic [11:0] result;
    } asmd_entry_t;

endpackage

// *** asmd_fifo.sv ***
`timescale 1ns/1ps
`include "asmd_defines.svh"

module asmd_fifo
#(
    parameter int WIDTH = `ASMD_FIFO_W,
    parameter int DEPTH = `ASMD_FIFO_DEPTH
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // housekeeping
    input wire logic flush
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic empty;
    logic do_write;
    logic do_read;

    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
    assign do_write = in_valid && in_ready;
    assign do_read = !empty && (!out_valid || out_ready);

    always_ff @(posedge clk_sys)
    begin
        if (do_write)
        begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (do_write)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_read)
            begin
                out_data <= mem[rd_ptr_reg[AW-1:0]];
                out_valid <= 1'b1;
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            else if (out_ready)
            begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// *** asmd_top_sva.sv ***
`timescale 1ns/1ps

module asmd_top_sva
    import asmd_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // watched signals
    input wire logic avg_request,
    input wire logic conv_start_reg,
    input wire logic [3:0] conv_channel_reg,
    input wire logic [3:0] scan_mode_reg,
    input wire logic [3:0] channel_number_field_reg,
    input wire logic software_convert_bit_reg,
    input wire logic ext_clock_mode_reg,
    input wire logic avg_active_reg,
    input wire logic busy_reg,
    input wire logic fifo_valid,
    input wire logic fifo_ready,
    input wire logic [15:0] fifo_data
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic int_mode;
    assign int_mode = scan_mode_reg == 4'h2 || scan_mode_reg == 4'h3;

    a_ext_clock: assert property (
        1'b1 |=> ext_clock_mode_reg == !$past(int_mode))
        else $error("clock mode flag wrong");
    a_avg_flag: assert property (
        1'b1 |=> avg_active_reg == ($past(avg_request) && $past(int_mode)))
        else $error("averaging flag wrong");
    a_start_pulse: assert property (
        conv_start_reg |=> !conv_start_reg)
        else $error("start pulse too long");
    a_busy_start: assert property (
        $rose(busy_reg) && int_mode |-> conv_start_reg)
        else $error("no start after run begins");
    a_repeat_chan: assert property (
        conv_start_reg && scan_mode_reg == 4'h2
        |-> conv_channel_reg == channel_number_field_reg)
        else $error("repeat channel wrong");
    a_manual_chan: assert property (
        conv_start_reg && scan_mode_reg == 4'h1
        |-> conv_channel_reg == channel_number_field_reg)
        else $error("manual channel wrong");
    a_scan_first: assert property (
        $rose(busy_reg) && scan_mode_reg == 4'h3
        |-> conv_start_reg && conv_channel_reg == 4'h0)
        else $error("scan does not begin at zero");
    a_scan_limit: assert property (
        conv_start_reg && scan_mode_reg == 4'h3
        |-> conv_channel_reg <= channel_number_field_reg)
        else $error("scan beyond limit");
    a_hold_scan: assert property (
        $changed(scan_mode_reg) |-> scan_mode_reg != 4'h0)
        else $error("hold code stored as mode");
    a_software_convert_bit_start: assert property (
        $fell(software_convert_bit_reg) && $rose(busy_reg)
        |-> conv_start_reg && !ext_clock_mode_reg)
        else $error("software convert did not start");
    a_fifo_hold: assert property (
        fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data))
        else $error("fifo output dropped");

    c_manual: cover property (conv_start_reg && scan_mode_reg == 4'h1);
    c_repeat: cover property (conv_start_reg && scan_mode_reg == 4'h2);
    c_scan: cover property (conv_start_reg && scan_mode_reg == 4'h3);
endmodule

bind asmd_top asmd_top_sva u_sva
(
    .clk_sys, .rst_n, .avg_request, .conv_start_reg, .conv_channel_reg,
    .scan_mode_reg, .channel_number_field_reg, .software_convert_bit_reg,
    .ext_clock_mode_reg, .avg_active_reg, .busy_reg, .fifo_valid,
    .fifo_ready, .fifo_data
);

// *** asmd_host_model.sv ***
`timescale 1ns/1ps

module asmd_host_model
(
    // serial link to the device
    output logic sclk,
    output logic cs_n,
    output logic din
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b1;
    end

    // one frame, clock idle low outside it
    task automatic send_word(input logic [15:0] w);
        #7;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            din = w[i];
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        din = ~din;
    endtask

    // empty frame, only the select edge
    task automatic cs_pulse();
        #7 cs_n = 1'b0;
        #64 cs_n = 1'b1;
        din = ~din;
    endtask
endmodule

// *** asmd_top_bench.sv ***
`timescale 1ns/1ps

module asmd_top_bench
    import asmd_pkg::*;
;
    logic clk_sys, rst_n, sclk, cs_n, din, cnvst_n, avg_request;
    logic conv_done, fifo_ready, conv_start_reg, busy_reg, fifo_valid;
    logic software_convert_bit_reg, ext_clock_mode_reg, avg_active_reg;
    logic manual_valid_reg;
    logic [1:0] repeat_count_sel;
    logic [3:0] conv_channel_reg, scan_mode_reg, ctrl_bits_reg;
    logic [3:0] channel_number_field_reg;
    logic [11:0] conv_result;
    logic [15:0] manual_result_reg, fifo_data;
    logic [7:0] pend;
    int lat, miscompares, total_checks, cycles;

    asmd_top DUT (.clk_sys, .rst_n, .sclk, .cs_n, .din, .cnvst_n,
        .repeat_count_sel, .avg_request, .conv_start_reg, .conv_channel_reg,
        .conv_done, .conv_result, .scan_mode_reg, .channel_number_field_reg,
        .ctrl_bits_reg, .software_convert_bit_reg, .ext_clock_mode_reg,
        .avg_active_reg, .busy_reg, .manual_result_reg, .manual_valid_reg,
        .fifo_valid, .fifo_ready, .fifo_data);
    asmd_host_model HOST (.sclk, .cs_n, .din);

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // converter core, answers after lat cycles
    always @(negedge clk_sys)
    begin
        pend <= {pend[6:0], conv_start_reg};
        conv_done <= (lat == 0) ? conv_start_reg : pend[lat-1];
        conv_result <= {8'hA0, conv_channel_reg};
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic send(input logic [15:0] w);
        HOST.send_word(w);
        repeat (12) @(negedge clk_sys);
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        repeat (6) @(negedge clk_sys);
        while (busy_reg !== 1'b0 && n < 3000)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(busy_reg, 16'h0000, "run end");
    endtask

    // far side stalls until the run ends, then drains
    task automatic drain(input int cnt, input logic [3:0] ch, step);
        int k;
        for (int i = 0; i < cnt; i++)
        begin
            k = 0;
            while (fifo_valid !== 1'b1 && k < 50)
            begin
                @(negedge clk_sys);
                k++;
            end
            chk(fifo_data, {ch, 8'hA0, ch}, "fifo entry");
            fifo_ready = 1'b1;
            @(negedge clk_sys);
            fifo_ready = 1'b0;
            ch = ch + step;
        end
        repeat (4) @(negedge clk_sys);
        chk(fifo_valid, 16'h0000, "fifo empty");
    endtask

    task automatic t_reset();
        chk(scan_mode_reg, 16'h0001, "reset scan");
        chk(channel_number_field_reg, 16'h0000, "reset chan");
        chk(ext_clock_mode_reg, 16'h0001, "reset clock");
        send(16'h9B80);
        chk(scan_mode_reg, 16'h0001, "config word scan");
        chk(channel_number_field_reg, 16'h0000, "config word chan");
    endtask

    task automatic t_manual();
        lat = 2;
        for (int i = 0; i < 2; i++)
        begin
            send(i ? 16'h0E00 : 16'h0A80);
            wait_run();
            chk(manual_valid_reg, 16'h0001, "manual valid");
            chk(manual_result_reg, i ? 16'hCA0C : 16'h5A05, "manual");
            chk(channel_number_field_reg, i ? 16'hC : 16'h5, "chan");
            chk(avg_active_reg, 16'h0000, "manual avg");
        end
    endtask

    task automatic t_repeat();
        // done must arrive while the sequencer waits, not in its start cycle
        lat = 1;
        send(16'h1480);
        chk(ext_clock_mode_reg, 16'h0000, "repeat clock");
        chk(avg_active_reg, 16'h0001, "repeat avg");
        for (int s = 0; s < 4; s++)
        begin
            repeat_count_sel = s[1:0];
            cnvst_n = 1'b0;
            repeat (3) @(negedge clk_sys);
            cnvst_n = 1'b1;
            wait_run();
            drain(4 * (s + 1), 4'h9, 4'h0);
        end
    endtask

    task automatic t_scan();
        lat = 3;
        send(16'h1980);
        send(16'h07AA);
        chk(scan_mode_reg, 16'h0003, "hold keeps scan");
        chk(channel_number_field_reg, 16'h0003, "hold keeps chan");
        chk(ctrl_bits_reg, 16'h0005, "hold ctrl");
        chk(software_convert_bit_reg, 16'h0001, "hold software_convert_bit");
        chk(ext_clock_mode_reg, 16'h0000, "scan clock");
        HOST.cs_pulse();
        wait_run();
        drain(4, 4'h0, 4'h1);
        chk(software_convert_bit_reg, 16'h0000, "software_convert_bit used");
    endtask

    initial
    begin
        rst_n = 1'b0;
        cnvst_n = 1'b1;
        fifo_ready = 1'b0;
        avg_request = 1'b1;
        repeat_count_sel = 2'h0;
        lat = 0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_manual();
        t_repeat();
        t_scan();
        print_verdict();
    end
endmodule
